// *** p1io_board.sv ***
// Board devices on the port one pins.
// Assumes enables high while the port drives a pin.
`timescale 1ns/1ps
`default_nettype none
module p1io_board (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] ext,
    output logic [7:0] pinIn
);
    // Pin level from the port where driven, else from the board
    assign pinIn = (pinOut & pinOe) | (ext & ~pinOe);
endmodule // p1io_board
`default_nettype wire

// *** p1io_chk.sv ***
// Assertions on the port one bus handshake, pin enables and control copies.
// Assumes binding to p1io_port on its single clock.
`timescale 1ns/1ps
`default_nettype none
`include "p1io_regs.svh"
module p1io_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic hwStandby,
    input wire logic swStandby,
    input wire logic standbyOutputHold,
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic selCsOneOrSeven,
    input wire logic selCsThreeOrSix,
    input wire logic portfPin1CsFiveEnable,
    input wire logic portfPin0CsFourEnable
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    wait_pulse_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    req_answer_a: assert property ((read || write) && waitrequest |-> ##[0:2] !waitrequest)
        else $error("request not answered in time");
    read_upper_a: assert property (!waitrequest && read |-> readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    dir_read_a: assert property (!waitrequest && read && address == {`P1IO_IDX_DIR, 2'b00}
        |-> readdata[7:0] == `P1IO_UNDEF_READ)
        else $error("direction read not the undefined value");
    reset_clr_a: assert property (disable iff (1'b0) !reset_n |=> waitrequest && pinOe == 8'h00)
        else $error("outputs not cleared by reset");
    hw_clear_a: assert property (hwStandby [*3] |-> pinOe == 8'h00 && pinOut == 8'h00
        && !selCsOneOrSeven && !portfPin0CsFourEnable)
        else $error("outputs not cleared in hardware standby");
    sw_hold_a: assert property ((swStandby && standbyOutputHold) [*3] |-> $stable(pinOe) && $stable(pinOut))
        else $error("pins changed while held in software standby");
    dir_follow_a: assert property (!waitrequest && write && byteenable[0] && !swStandby && !hwStandby
        && address == {`P1IO_IDX_DIR, 2'b00} |-> ##2 pinOe == $past(writedata[7:0], 2))
        else $error("pin enables do not follow direction write");
    cs_follow_a: assert property (!waitrequest && write && byteenable[0] && !swStandby && !hwStandby
        && address == {`P1IO_IDX_FUNC, 2'b00} |-> ##2 {selCsOneOrSeven, selCsThreeOrSix,
        portfPin1CsFiveEnable, portfPin0CsFourEnable} == $past(writedata[7:4], 2))
        else $error("chip select controls do not follow write");
endmodule // p1io_chk
bind p1io_port p1io_chk chk (.clock(clock), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .hwStandby(hwStandby), .swStandby(swStandby),
    .standbyOutputHold(standbyOutputHold), .pinOut(pinOut), .pinOe(pinOe),
    .selCsOneOrSeven(selCsOneOrSeven), .selCsThreeOrSix(selCsThreeOrSix),
    .portfPin1CsFiveEnable(portfPin1CsFiveEnable), .portfPin0CsFourEnable(portfPin0CsFourEnable));
`default_nettype wire

// *** p1io_pkg.sv ***
// Types shared by the port one block.
// Assumes p1io_regs.svh in the include path.
`default_nettype none
package p1io_pkg;

    // ----------------------------------------
    // Register selection and bus states
    // ----------------------------------------
    typedef enum logic [2:0] {
        REG_NONE,
        REG_DIR,
        REG_FUNC,
        REG_PINS,
        REG_DATA
    } p1io_reg_e;

    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } p1io_bus_e;

endpackage
`default_nettype wire

// *** p1io_port.sv ***
// Port one general purpose I/O with address enables, as an Avalon-MM slave.
// Assumes a 10 MHz clock, synchronous active-low reset, standby levels from the
// power controller on the same clock, and pins arriving from outside the clock domain.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "p1io_regs.svh"

module p1io_port
    import p1io_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [17:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic hwStandby,
    input wire logic swStandby,
    input wire logic standbyOutputHold,
    input wire logic [2:0] opMode,
    input wire logic [3:0] addrHigh,
    input wire logic [7:0] pinIn,
    output logic [7:0] pinOut,
    output logic [7:0] pinOe,
    output logic selCsOneOrSeven,
    output logic selCsThreeOrSix,
    output logic portfPin1CsFiveEnable,
    output logic portfPin0CsFourEnable
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function automatic p1io_reg_e decodeReg(input logic [17:0] addr);
        p1io_reg_e sel;
        sel = REG_NONE;
        if (addr[1:0] != 2'h0)
        begin
            sel = REG_NONE;
        end
        else if (addr[17:2] == `P1IO_IDX_DIR)
        begin
            sel = REG_DIR;
        end
        else if (addr[17:2] == `P1IO_IDX_FUNC)
        begin
            sel = REG_FUNC;
        end
        else if (addr[17:2] == `P1IO_IDX_PINS)
        begin
            sel = REG_PINS;
        end
        else if (addr[17:2] == `P1IO_IDX_DATA)
        begin
            sel = REG_DATA;
        end
        return sel;
    endfunction

    function automatic logic [7:0] mergeView(
        input logic [7:0] dir,
        input logic [7:0] data,
        input logic [7:0] pins
    );
        return (dir & data) | (~dir & pins);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    p1io_bus_e busState_ff;
    p1io_bus_e nxt_busState;
    p1io_reg_e regSel;
    logic clearAll;
    logic request;
    logic accessDone;
    logic writeLow;
    logic addrModeOn;
    logic [7:0] dir_ff;
    logic [7:0] data_ff;
    logic [7:0] func_ff;
    logic [7:0] pinView_ff;
    logic [7:0] pinMeta_ff;
    logic [7:0] pinSync_ff;
    logic [31:0] readdata_ff;
    logic waitrequest_ff;
    logic [7:0] pinOut_ff;
    logic [7:0] pinOe_ff;
    logic [7:0] nxt_pinOut;
    logic [7:0] nxt_pinOe;
    logic [7:0] nxt_readByte;
    logic [3:0] addrEn;

    // ----------------------------------------
    // Common terms
    // ----------------------------------------
    assign clearAll = !reset_n || hwStandby;
    assign request = read || write;
    assign accessDone = (busState_ff == BUS_ACK);
    assign writeLow = write && accessDone && byteenable[0];
    assign regSel = decodeReg(address);
    assign addrEn = func_ff[`P1IO_ADDR_EN_MSB:`P1IO_ADDR_EN_LSB];
    assign addrModeOn = (opMode >= `P1IO_MODE_ADDR_LO) && (opMode <= `P1IO_MODE_ADDR_HI);

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------
    always_comb
    begin
        nxt_busState = busState_ff;
        case (busState_ff)
            BUS_IDLE:
            begin
                if (request)
                begin
                    nxt_busState = BUS_ACK;
                end
            end
            BUS_ACK:
            begin
                nxt_busState = BUS_IDLE;
            end
            default:
            begin
                nxt_busState = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            busState_ff <= BUS_IDLE;
        end
        else
        begin
            busState_ff <= nxt_busState;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            waitrequest_ff <= 1'b1;
        end
        else
        begin
            waitrequest_ff <= !(nxt_busState == BUS_ACK);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb
    begin
        nxt_readByte = 8'h00;
        case (regSel)
            REG_DIR:
            begin
                nxt_readByte = `P1IO_UNDEF_READ;
            end
            REG_FUNC:
            begin
                nxt_readByte = func_ff;
            end
            REG_PINS:
            begin
                nxt_readByte = pinView_ff;
            end
            REG_DATA:
            begin
                nxt_readByte = data_ff;
            end
            default:
            begin
                nxt_readByte = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            readdata_ff <= 32'h0000_0000;
        end
        else if (read && !accessDone)
        begin
            readdata_ff <= {24'h00_0000, nxt_readByte};
        end
    end

    // ----------------------------------------
    // Direction register
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (clearAll)
        begin
            dir_ff <= `P1IO_RST_DIR;
        end
        else if (writeLow && regSel == REG_DIR)
        begin
            dir_ff <= writedata[7:0];
        end
    end

    // ----------------------------------------
    // Output data register
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (clearAll)
        begin
            data_ff <= `P1IO_RST_DATA;
        end
        else if (writeLow && regSel == REG_DATA)
        begin
            data_ff <= writedata[7:0];
        end
    end

    // ----------------------------------------
    // Function control register
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (clearAll)
        begin
            func_ff <= `P1IO_RST_FUNC;
        end
        else if (writeLow && regSel == REG_FUNC)
        begin
            func_ff <= writedata[7:0];
        end
    end

    always_ff @(posedge clock)
    begin
        if (clearAll)
        begin
            selCsOneOrSeven <= 1'(`P1IO_RST_FUNC >> `P1IO_BIT_CS17);
            selCsThreeOrSix <= 1'(`P1IO_RST_FUNC >> `P1IO_BIT_CS36);
            portfPin1CsFiveEnable <= 1'(`P1IO_RST_FUNC >> `P1IO_BIT_CS5EN);
            portfPin0CsFourEnable <= 1'(`P1IO_RST_FUNC >> `P1IO_BIT_CS4EN);
        end
        else
        begin
            selCsOneOrSeven <= func_ff[`P1IO_BIT_CS17];
            selCsThreeOrSix <= func_ff[`P1IO_BIT_CS36];
            portfPin1CsFiveEnable <= func_ff[`P1IO_BIT_CS5EN];
            portfPin0CsFourEnable <= func_ff[`P1IO_BIT_CS4EN];
        end
    end

    // ----------------------------------------
    // Pin synchroniser
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            pinMeta_ff <= 8'h00;
            pinSync_ff <= 8'h00;
        end
        else
        begin
            pinMeta_ff <= pinIn;
            pinSync_ff <= pinMeta_ff;
        end
    end

    // ----------------------------------------
    // Pin-level view, writes never reach it
    // ----------------------------------------
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            pinView_ff <= `P1IO_RST_PINS;
        end
        else if (hwStandby)
        begin
            pinView_ff <= pinSync_ff;
        end
        else if (!swStandby)
        begin
            pinView_ff <= mergeView(dir_ff, data_ff, pinSync_ff);
        end
    end

    // ----------------------------------------
    // Output source multiplexer
    // ----------------------------------------
    always_comb
    begin
        nxt_pinOut = data_ff;
        nxt_pinOe = dir_ff;
        for (int i = 0; i < 4; i++)
        begin
            if (addrModeOn && addrEn[i])
            begin
                nxt_pinOut[i] = addrHigh[i];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (clearAll)
        begin
            pinOut_ff <= 8'h00;
            pinOe_ff <= 8'h00;
        end
        else if (swStandby)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (addrModeOn && addrEn[i] && !standbyOutputHold)
                begin
                    pinOe_ff[i] <= 1'b0;
                end
            end
        end
        else
        begin
            pinOut_ff <= nxt_pinOut;
            pinOe_ff <= nxt_pinOe;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign readdata = readdata_ff;
    assign waitrequest = waitrequest_ff;
    assign pinOut = pinOut_ff;
    assign pinOe = pinOe_ff;

endmodule // p1io_port
`default_nettype wire

// *** p1io_port_tb.sv ***
// Self-checking bench of the port one block against a register model.
// Assumes p1io_pkg, p1io_port, p1io_board and p1io_chk compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "p1io_regs.svh"
module p1io_port_tb
    import p1io_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [17:0] address = 18'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic hwStandby = 1'b0;
    logic swStandby = 1'b0;
    logic standbyOutputHold = 1'b1;
    logic [2:0] opMode = 3'h0;
    logic [3:0] addrHigh = 4'h0;
    logic [7:0] ext = 8'h00;
    logic [7:0] pinIn, pinOut, pinOe, mDir = 8'h00, mData = 8'h00, mFunc = 8'h0F, v;
    logic [31:0] readdata, rd;
    logic waitrequest, cs17, cs36, cs5, cs4;
    int num_errors = 0;
    int samples_checked = 0;
    always #50 clock = ~clock;
    p1io_port DUT (.clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .hwStandby(hwStandby), .swStandby(swStandby), .standbyOutputHold(standbyOutputHold),
        .opMode(opMode), .addrHigh(addrHigh), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .selCsOneOrSeven(cs17), .selCsThreeOrSix(cs36), .portfPin1CsFiveEnable(cs5),
        .portfPin0CsFourEnable(cs4));
    p1io_board board (.pinOut(pinOut), .pinOe(pinOe), .ext(ext), .pinIn(pinIn));
    task automatic conclude();
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input bit w, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        address <= {idx, 2'b00};
        write <= w;
        read <= !w;
        writedata <= {24'h0, wd};
        do
        begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rd = readdata;
        if (n >= 20)
        begin
            num_errors++;
            conclude();
        end
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
        if (byteenable[0] && idx == `P1IO_IDX_DIR) mDir = d;
        if (byteenable[0] && idx == `P1IO_IDX_DATA) mData = d;
        if (byteenable[0] && idx == `P1IO_IDX_FUNC) mFunc = d;
    endtask
    task automatic rdc(input string name, input logic [15:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(name, exp, rd[7:0]);
    endtask
    task automatic chkPins();
        logic [7:0] m, e;
        repeat (3) @(posedge clock);
        m = (opMode >= `P1IO_MODE_ADDR_LO && opMode <= `P1IO_MODE_ADDR_HI) ? {4'h0, mFunc[3:0]} : 8'h00;
        e = (mData & ~m) | ({4'h0, addrHigh} & m);
        chk("pinOe", mDir, pinOe);
        chk("pinOut", e & mDir, pinOut & mDir);
        chk("csSel", {4'h0, mFunc[7:4]}, {4'h0, cs17, cs36, cs5, cs4});
        rdc("pins", `P1IO_IDX_PINS, (mData & mDir) | (ext & ~mDir));
    endtask
    initial
    begin
        rd = $urandom(32'h2F9F977D);
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rdc("func", `P1IO_IDX_FUNC, `P1IO_RST_FUNC);
        rdc("data", `P1IO_IDX_DATA, `P1IO_RST_DATA);
        rdc("dir", `P1IO_IDX_DIR, `P1IO_UNDEF_READ);
        ext <= 8'hA5;
        chkPins();
        for (int i = 0; i < 16; i++)
        begin
            opMode <= i[2:0];
            addrHigh <= 4'($urandom);
            ext <= 8'($urandom);
            wr(`P1IO_IDX_FUNC, 8'($urandom));
            wr(`P1IO_IDX_DIR, 8'($urandom));
            wr(`P1IO_IDX_DATA, 8'($urandom));
            chkPins();
            rdc("data", `P1IO_IDX_DATA, mData);
        end
        wr(`P1IO_IDX_PINS, 8'h3C);
        wr(16'h1234, 8'h3C);
        byteenable <= 4'hE;
        wr(`P1IO_IDX_DATA, ~mData);
        byteenable <= 4'hF;
        rdc("data", `P1IO_IDX_DATA, mData);
        rdc("unmapped", 16'h1234, 8'h00);
        opMode <= 3'h4;
        wr(`P1IO_IDX_FUNC, 8'h0F);
        wr(`P1IO_IDX_DIR, 8'h3F);
        chkPins();
        v = (mData & mDir) | (ext & ~mDir);
        swStandby <= 1'b1;
        ext <= ~ext;
        repeat (4) @(posedge clock);
        rdc("swPins", `P1IO_IDX_PINS, v);
        standbyOutputHold <= 1'b0;
        repeat (4) @(posedge clock);
        chk("floatOe", 8'h30, pinOe);
        swStandby <= 1'b0;
        standbyOutputHold <= 1'b1;
        chkPins();
        hwStandby <= 1'b1;
        repeat (4) @(posedge clock);
        chk("hwOe", 8'h00, pinOe);
        hwStandby <= 1'b0;
        mDir = 8'h00;
        mData = 8'h00;
        mFunc = `P1IO_RST_FUNC;
        @(posedge clock);
        rdc("func", `P1IO_IDX_FUNC, `P1IO_RST_FUNC);
        chkPins();
        conclude();
    end
endmodule // p1io_port_tb
`default_nettype wire

// *** p1io_regs.svh ***
// Register map, reset values, field positions and address-enable operating modes of the port one block.
// Assumes inclusion by the port module, the checker and the bench.
//
// Operation
// - Direction bit 1 makes the pin an output, 0 an input.
// - Direction register is write-only; reads return an undefined constant.
// - Direction clears on reset and hardware standby, holds in software standby.
// - Output data register is read/write, clears to zero, holds in software standby.
// - Pin-level register is read-only; writes are ignored.
// - Pin-level read returns output data where the direction bit is 1.
// - Pin-level read returns the sampled pin where the direction bit is 0.
// - Function control resets to 0F on reset and hardware standby.
// - Output pins 3..0 with address enable set drive address bits 23..20.
// - Output pins 3..0 with address enable clear drive their data bit.
// - Address enables act only in operating modes 4 to 6.
// - Control bit 7 routes chip select 1 or 7 to port G pin 3.
// - Control bit 6 routes chip select 3 or 6 to port G pin 1.
// - Control bits 5, 4 enable chip selects 5, 4 on port F.
// - Software standby: address pins hold or float per the hold bit.
// - Pin-level view tracks pins after reset, freezes in software standby.
// - Pins also carry address outputs 23..20 depending on mode.
`ifndef P1IO_REGS_SVH
`define P1IO_REGS_SVH

// ----------------------------------------
// Register indices, byte address is four times
// ----------------------------------------
`define P1IO_IDX_DIR 16'hFEB0
`define P1IO_IDX_FUNC 16'hFF45
`define P1IO_IDX_PINS 16'hFF50
`define P1IO_IDX_DATA 16'hFF60

// ----------------------------------------
// Reset values
// ----------------------------------------
`define P1IO_RST_DIR 8'h00
`define P1IO_RST_DATA 8'h00
`define P1IO_RST_FUNC 8'h0F
`define P1IO_RST_PINS 8'h00
`define P1IO_UNDEF_READ 8'hFF

// ----------------------------------------
// Function control fields
// ----------------------------------------
`define P1IO_BIT_CS17 7
`define P1IO_BIT_CS36 6
`define P1IO_BIT_CS5EN 5
`define P1IO_BIT_CS4EN 4
`define P1IO_ADDR_EN_LSB 0
`define P1IO_ADDR_EN_MSB 3

// ----------------------------------------
// Operating modes with address enables valid
// ----------------------------------------
`define P1IO_MODE_ADDR_LO 3'h4
`define P1IO_MODE_ADDR_HI 3'h6

`endif
